// ==== logic/sysid_bank.sv ====
/*
 * identification and cache-description register bank for primary
 * register number zero. answers one move instruction per cycle.
 * assumes requests come from the core's decode stage on i_core_clk and
 * that configuration pins are static straps from outside the core.
 */
`timescale 1ns/10ps
module sysid_bank #(
    // value is arbitrary, not any real maker's code
    parameter logic [31:0] MAIN_IDENTITY_VAL = 32'h5A000000
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_acc_valid,
    input wire sysid_pkg::sysid_req_type i_acc_req,
    input wire logic [3:0] i_cluster_number_input,
    input wire logic [1:0] i_core_number,
    input wire logic i_l2_present,
    input wire logic i_security_write_disable,
    output logic o_acc_ready,
    output sysid_pkg::sysid_rsp_type o_acc_rsp
);
    import sysid_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] sysid_csize(input logic [3:0] sel,
                                                input logic l2);
        logic [31:0] w;
        w = ZERO_WORD;
        if (sel == 4'h0) begin
            w = CSIZE_L1D;
        end else if (sel == 4'h1) begin
            w = CSIZE_L1I;
        end else if (sel == 4'h2 && l2) begin
            w = CSIZE_L2;
        end
        return w;
    endfunction

    function automatic logic sysid_block(input sysid_sel_type s,
                                         input logic [3:0] sec);
        return s.primary_register_number == 4'h0 &&
               s.first_opcode == 3'h0 &&
               s.secondary_register_number == sec;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and configuration capture
    // ----------------------------------------------------------------
    logic [3:0] clus_m_q, clus_s_q;
    logic [1:0] core_m_q, core_s_q;
    logic l2_m_q, l2_s_q, sdis_m_q, sdis_s_q;
    logic [1:0] cfg_cnt_q;
    logic loaded_q;
    logic [31:0] affinity_q;
    logic l2_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clus_m_q <= 4'h0;
            clus_s_q <= 4'h0;
            core_m_q <= 2'h0;
            core_s_q <= 2'h0;
            l2_m_q <= 1'b0;
            l2_s_q <= 1'b0;
            sdis_m_q <= 1'b0;
            sdis_s_q <= 1'b0;
        end else begin
            clus_m_q <= i_cluster_number_input;
            clus_s_q <= clus_m_q;
            core_m_q <= i_core_number;
            core_s_q <= core_m_q;
            l2_m_q <= i_l2_present;
            l2_s_q <= l2_m_q;
            sdis_m_q <= i_security_write_disable;
            sdis_s_q <= sdis_m_q;
        end
    end

    // straps are taken once, after the synchronisers have settled, so a
    // pin that moves later cannot disturb the reported identity
    wire cfg_take = !loaded_q && cfg_cnt_q == CFG_LOAD_CYC;
    wire [31:0] affinity_d = AFF_BASE |
        (32'(clus_s_q) << AFF_CLUSTER_LSB) |
        (32'(core_s_q) << AFF_CORE_LSB);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_cnt_q <= 2'h0;
            loaded_q <= 1'b0;
            affinity_q <= AFF_BASE;
            l2_q <= 1'b0;
        end else begin
            if (!loaded_q && cfg_cnt_q != CFG_LOAD_CYC) begin
                cfg_cnt_q <= cfg_cnt_q + 2'h1;
            end
            if (cfg_take) begin
                loaded_q <= 1'b1;
                affinity_q <= affinity_d;
                l2_q <= l2_s_q;
            end
        end
    end

    assign o_acc_ready = loaded_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    sysid_sel_type sel;
    assign sel = i_acc_req.sel;
    wire take = i_acc_valid && loaded_q;
    wire is_feat = sysid_block(sel, SEC_FEATURE);
    wire is_isa = sysid_block(sel, SEC_ISA) && sel.second_opcode <= ISA_LAST;
    wire is_main = sel == SEL_MAIN || sel == SEL_ALIAS4 ||
                   sel == SEL_ALIAS7;
    wire is_cssel = sel == SEL_CSSEL;
    wire is_vproc = sel == SEL_VPROC;
    wire is_vaff = sel == SEL_VAFF;
    wire is_wr_reg = is_cssel || is_vproc || is_vaff;
    // selectors below belong to this bank; anything else is undefined
    wire is_known = is_main || is_feat || is_isa || is_wr_reg ||
                    sel == SEL_CTYPE || sel == SEL_TCM || sel == SEL_TLB ||
                    sel == SEL_AFF || sel == SEL_REV ||
                    sel == SEL_CSIZE || sel == SEL_CLEVEL ||
                    sel == SEL_AUXID;
    wire wr_blocked = i_acc_req.write && is_wr_reg && sdis_s_q;
    wire undef_d = !is_known || wr_blocked;
    wire wr_ok = take && i_acc_req.write && is_wr_reg && !sdis_s_q;

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    logic [31:0] cssel_q, vproc_q, vaff_q;

    // selector resets to CSSEL_RST, which selects the level-one data cache size
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cssel_q <= CSSEL_RST;
            vproc_q <= MAIN_IDENTITY_VAL;
            vaff_q <= AFF_BASE;
        end else if (cfg_take) begin
            vaff_q <= affinity_d;
        end else if (wr_ok) begin
            if (is_cssel) begin
                cssel_q <= i_acc_req.wdata & CSSEL_MASK;
            end
            if (is_vproc) begin
                vproc_q <= i_acc_req.wdata;
            end
            if (is_vaff) begin
                vaff_q <= i_acc_req.wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // read multiplexer
    // ----------------------------------------------------------------
    wire [31:0] clevel = l2_q ? CLEVEL_L2 : CLEVEL_L1;
    wire [31:0] csize = sysid_csize(cssel_q[3:0], l2_q);
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = ZERO_WORD;
        if (is_main) begin
            rd_mux = MAIN_IDENTITY_VAL;
        end else if (sel == SEL_CTYPE) begin
            rd_mux = CACHE_TYPE_RST;
        end else if (sel == SEL_AFF) begin
            rd_mux = affinity_q;
        end else if (sel == SEL_REV) begin
            rd_mux = REVISION_RST;
        end else if (is_feat) begin
            rd_mux = FEATURE_RST[sel.second_opcode];
        end else if (is_isa) begin
            rd_mux = ISA_RST[sel.second_opcode];
        end else if (sel == SEL_CSIZE) begin
            rd_mux = csize;
        end else if (sel == SEL_CLEVEL) begin
            rd_mux = clevel;
        end else if (is_cssel) begin
            rd_mux = cssel_q;
        end else if (is_vproc) begin
            rd_mux = vproc_q;
        end else if (is_vaff) begin
            rd_mux = vaff_q;
        end
    end

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    // writes and undefined accesses return zero data
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_acc_rsp <= '0;
        end else begin
            o_acc_rsp.done <= take;
            o_acc_rsp.undef <= take && undef_d;
            o_acc_rsp.rdata <= (take && !i_acc_req.write && !undef_d) ?
                               rd_mux : ZERO_WORD;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking sysid_cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    wire rd_take = take && !i_acc_req.write;

    main_alias_a: assert property (
        rd_take && (sel == SEL_ALIAS4 || sel == SEL_ALIAS7)
        |=> o_acc_rsp.done && o_acc_rsp.rdata == MAIN_IDENTITY_VAL)
        else $error("identity alias read wrong");

    cache_type_a: assert property (
        rd_take && sel == SEL_CTYPE |=> o_acc_rsp.rdata == CACHE_TYPE_RST)
        else $error("cache type read wrong");

    zero_types_a: assert property (
        rd_take && (sel == SEL_TCM || sel == SEL_TLB || sel == SEL_AUXID)
        |=> o_acc_rsp.rdata == ZERO_WORD && !o_acc_rsp.undef)
        else $error("zero register read wrong");

    affinity_read_a: assert property (
        rd_take && sel == SEL_AFF |=> o_acc_rsp.rdata[31] &&
        o_acc_rsp.rdata[11:8] == $past(affinity_q[11:8]))
        else $error("affinity read wrong");

    cfg_capture_a: assert property (
        $rose(loaded_q) |-> affinity_q == $past(affinity_d) &&
        vaff_q == affinity_q ##1 $stable(affinity_q) [*4])
        else $error("configuration capture wrong");

    unmapped_undef_a: assert property (
        take && sel.primary_register_number != 4'h0
        |=> o_acc_rsp.undef && o_acc_rsp.rdata == ZERO_WORD)
        else $error("unmapped selector not undefined");

    sdis_write_a: assert property (
        take && i_acc_req.write && is_cssel && sdis_s_q
        |=> o_acc_rsp.undef && $stable(cssel_q))
        else $error("protected write not refused");

    ro_write_a: assert property (
        take && i_acc_req.write && is_known && !is_wr_reg
        |=> !o_acc_rsp.undef && $stable(cssel_q) && $stable(vproc_q))
        else $error("read-only write had effect");

    csize_follow_a: assert property (
        take && i_acc_req.write && is_cssel && !sdis_s_q &&
        i_acc_req.wdata[3:0] == 4'h1 ##1 rd_take && sel == SEL_CSIZE
        |=> o_acc_rsp.rdata == CSIZE_L1I)
        else $error("cache size does not follow selector");

    done_pulse_a: assert property (
        take |=> o_acc_rsp.done ##1 (o_acc_rsp.done == $past(take)))
        else $error("done pulse wrong");

    ready_hold_a: assert property (
        o_acc_ready |=> o_acc_ready)
        else $error("ready dropped after capture");

    idle_quiet_a: assert property (
        !take |=> !o_acc_rsp.done && !o_acc_rsp.undef &&
        o_acc_rsp.rdata == ZERO_WORD)
        else $error("response without request");

    main_read_a: assert property (
        rd_take && sel == SEL_MAIN
        |=> o_acc_rsp.rdata == MAIN_IDENTITY_VAL && !o_acc_rsp.undef)
        else $error("main identity read wrong");

    clevel_l2_a: assert property (
        rd_take && sel == SEL_CLEVEL && l2_q
        |=> o_acc_rsp.rdata == CLEVEL_L2)
        else $error("cache level with level two wrong");

    clevel_l1_a: assert property (
        rd_take && sel == SEL_CLEVEL && !l2_q
        |=> o_acc_rsp.rdata == CLEVEL_L1)
        else $error("cache level without level two wrong");

    vproc_reset_a: assert property (
        $rose(loaded_q) |-> vproc_q == MAIN_IDENTITY_VAL)
        else $error("virtual processor identity reset wrong");

    cssel_reset_a: assert property (
        $rose(loaded_q) |-> cssel_q == CSSEL_RST)
        else $error("cache size selector reset wrong");

    cssel_write_a: assert property (
        wr_ok && is_cssel
        |=> cssel_q == ($past(i_acc_req.wdata) & CSSEL_MASK))
        else $error("cache size selector write wrong");

    sdis_vproc_a: assert property (
        take && i_acc_req.write && (is_vproc || is_vaff) && sdis_s_q
        |=> o_acc_rsp.undef && $stable(vproc_q) && $stable(vaff_q))
        else $error("protected identity write not refused");

    csize_l2_a: assert property (
        take && i_acc_req.write && is_cssel && !sdis_s_q &&
        i_acc_req.wdata[3:0] == 4'h2 ##1 rd_take && sel == SEL_CSIZE &&
        l2_q |=> o_acc_rsp.rdata == CSIZE_L2)
        else $error("level two cache size wrong");

    // one check per constant word, so a swapped table entry is caught
    proc_feat0_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h0
        |=> o_acc_rsp.rdata == FEATURE_RST[0])
        else $error("processor feature 0 read wrong");

    proc_feat1_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h1
        |=> o_acc_rsp.rdata == FEATURE_RST[1])
        else $error("processor feature 1 read wrong");

    debug_feat_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h2
        |=> o_acc_rsp.rdata == FEATURE_RST[2])
        else $error("debug feature read wrong");

    aux_feat_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h3
        |=> o_acc_rsp.rdata == ZERO_WORD)
        else $error("auxiliary feature read wrong");

    mem_feat0_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h4
        |=> o_acc_rsp.rdata == FEATURE_RST[4])
        else $error("memory model feature 0 read wrong");

    mem_feat1_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h5
        |=> o_acc_rsp.rdata == FEATURE_RST[5])
        else $error("memory model feature 1 read wrong");

    mem_feat2_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h6
        |=> o_acc_rsp.rdata == FEATURE_RST[6])
        else $error("memory model feature 2 read wrong");

    mem_feat3_a: assert property (
        rd_take && is_feat && sel.second_opcode == 3'h7
        |=> o_acc_rsp.rdata == FEATURE_RST[7])
        else $error("memory model feature 3 read wrong");

    isa_attr0_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h0
        |=> o_acc_rsp.rdata == ISA_RST[0])
        else $error("attribute 0 read wrong");

    isa_attr1_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h1
        |=> o_acc_rsp.rdata == ISA_RST[1])
        else $error("attribute 1 read wrong");

    isa_attr2_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h2
        |=> o_acc_rsp.rdata == ISA_RST[2])
        else $error("attribute 2 read wrong");

    isa_attr3_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h3
        |=> o_acc_rsp.rdata == ISA_RST[3])
        else $error("attribute 3 read wrong");

    isa_attr4_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h4
        |=> o_acc_rsp.rdata == ISA_RST[4])
        else $error("attribute 4 read wrong");

    isa_attr5_a: assert property (
        rd_take && is_isa && sel.second_opcode == 3'h5
        |=> o_acc_rsp.rdata == ZERO_WORD)
        else $error("attribute 5 read wrong");

endmodule // sysid_bank

// ==== include/sysid_pkg.sv ====
/*
 * constants, selector layout and carrier types of the identification
 * register bank reached by system coprocessor move instructions.
 * assumes the core decodes the instruction into the four selector fields.
 */
package sysid_pkg;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] primary_register_number;
        logic [2:0] first_opcode;
        logic [3:0] secondary_register_number;
        logic [2:0] second_opcode;
    } sysid_sel_type;

    typedef struct packed {
        logic write;
        sysid_sel_type sel;
        logic [31:0] wdata;
    } sysid_req_type;

    typedef struct packed {
        logic done;
        logic undef;
        logic [31:0] rdata;
    } sysid_rsp_type;

    // ----------------------------------------------------------------
    // selector values, {primary, first, secondary, second}
    // ----------------------------------------------------------------
    localparam sysid_sel_type SEL_MAIN = '{4'h0, 3'h0, 4'h0, 3'h0};
    localparam sysid_sel_type SEL_CTYPE = '{4'h0, 3'h0, 4'h0, 3'h1};
    localparam sysid_sel_type SEL_TCM = '{4'h0, 3'h0, 4'h0, 3'h2};
    localparam sysid_sel_type SEL_TLB = '{4'h0, 3'h0, 4'h0, 3'h3};
    localparam sysid_sel_type SEL_ALIAS4 = '{4'h0, 3'h0, 4'h0, 3'h4};
    localparam sysid_sel_type SEL_AFF = '{4'h0, 3'h0, 4'h0, 3'h5};
    localparam sysid_sel_type SEL_REV = '{4'h0, 3'h0, 4'h0, 3'h6};
    localparam sysid_sel_type SEL_ALIAS7 = '{4'h0, 3'h0, 4'h0, 3'h7};
    localparam sysid_sel_type SEL_CSIZE = '{4'h0, 3'h1, 4'h0, 3'h0};
    localparam sysid_sel_type SEL_CLEVEL = '{4'h0, 3'h1, 4'h0, 3'h1};
    localparam sysid_sel_type SEL_AUXID = '{4'h0, 3'h1, 4'h0, 3'h7};
    localparam sysid_sel_type SEL_CSSEL = '{4'h0, 3'h2, 4'h0, 3'h0};
    localparam sysid_sel_type SEL_VPROC = '{4'h0, 3'h4, 4'h0, 3'h0};
    localparam sysid_sel_type SEL_VAFF = '{4'h0, 3'h4, 4'h0, 3'h5};
    // feature blocks: primary 0, first 0, secondary 1 or 2
    localparam logic [3:0] SEC_FEATURE = 4'h1;
    localparam logic [3:0] SEC_ISA = 4'h2;

    // ----------------------------------------------------------------
    // reset and constant values
    // ----------------------------------------------------------------
    localparam logic [31:0] CACHE_TYPE_RST = 32'h84448003;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [31:0] REVISION_RST = 32'h00000000;
    localparam logic [31:0] FEATURE_RST [0:7] = '{
        32'h00001131, 32'h00011011, 32'h02010555, 32'h00000000,
        32'h10101105, 32'h40000000, 32'h01240000, 32'h02102211};
    localparam logic [31:0] ISA_RST [0:5] = '{
        32'h01101110, 32'h13112111, 32'h21232041,
        32'h11112131, 32'h10011142, 32'h00000000};
    localparam logic [2:0] ISA_LAST = 3'h5;
    localparam logic [31:0] CSSEL_RST = 32'h00000000;
    localparam logic [31:0] CSSEL_MASK = 32'h0000000F;
    // affinity layout: format bit, cluster field, core field
    localparam logic [31:0] AFF_BASE = 32'h80000000;
    localparam int AFF_CLUSTER_LSB = 8;
    localparam int AFF_CORE_LSB = 0;
    // cache level and geometry words (plain defaults)
    localparam logic [31:0] CLEVEL_L1 = 32'h09000003;
    localparam logic [31:0] CLEVEL_L2 = 32'h0A200023;
    localparam logic [31:0] CSIZE_L1D = 32'h00000001;
    localparam logic [31:0] CSIZE_L1I = 32'h00000002;
    localparam logic [31:0] CSIZE_L2 = 32'h00000003;
    // count reached before capture; configuration is captured on the third edge after reset release
    localparam logic [1:0] CFG_LOAD_CYC = 2'h2;

endpackage

// ==== dv/sysid_bank_test.sv ====
/*
 * self-checking bench for the identification register bank: reads every
 * word but the revision word, writes the writable ones, probes refusals and re-captures straps.
 * assumes the bank answers on the taking edge itself, checked 1 ns later, per hand-over.
 */
`timescale 1ns/10ps
// --------------------------------------------------------------------
// shared compare
// --------------------------------------------------------------------
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) begin \
            $display("mismatch %s exp %h got %h", nm, ex, got); \
            num_errors++; \
        end \
    end
module sysid_bank_test;
    import sysid_pkg::*;
    // value is arbitrary, not any real maker's code
    localparam logic [31:0] MAIN_VAL = 32'h5A000000;
    localparam logic [31:0] FEAT_EXP [0:7] = '{
        32'h00001131, 32'h00011011, 32'h02010555, 32'h00000000,
        32'h10101105, 32'h40000000, 32'h01240000, 32'h02102211};
    localparam logic [31:0] ISA_EXP [0:5] = '{
        32'h01101110, 32'h13112111, 32'h21232041,
        32'h11112131, 32'h10011142, 32'h00000000};
    logic i_core_clk;
    logic i_rst_n;
    logic i_acc_valid;
    sysid_req_type i_acc_req;
    logic [3:0] i_cluster_number_input;
    logic [1:0] i_core_number;
    logic i_l2_present;
    logic i_security_write_disable;
    logic o_acc_ready;
    sysid_rsp_type o_acc_rsp;
    int num_errors;
    int num_checks;

    sysid_bank #(.MAIN_IDENTITY_VAL(MAIN_VAL)) dut (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_acc_valid(i_acc_valid),
        .i_acc_req(i_acc_req),
        .i_cluster_number_input(i_cluster_number_input),
        .i_core_number(i_core_number),
        .i_l2_present(i_l2_present),
        .i_security_write_disable(i_security_write_disable),
        .o_acc_ready(o_acc_ready),
        .o_acc_rsp(o_acc_rsp)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic sysid_sel_type mk_sel(input logic [3:0] p,
        input logic [2:0] f, input logic [3:0] s, input logic [2:0] o);
        return '{p, f, s, o};
    endfunction

    // valid stays up on return so calls run back to back every cycle
    task automatic acc(input logic wr, input sysid_sel_type sel,
        input logic [31:0] wd, input logic ex_undef, input logic [31:0] ex);
        i_acc_valid = 1'b1;
        i_acc_req.write = wr;
        i_acc_req.sel = sel;
        i_acc_req.wdata = wd;
        @(posedge i_core_clk);
        #1;
        `CHK("done", 1'b1, o_acc_rsp.done)
        `CHK("undef", ex_undef, o_acc_rsp.undef)
        `CHK("rdata", ex, o_acc_rsp.rdata)
    endtask

    task automatic rd(input sysid_sel_type sel, input logic [31:0] ex);
        acc(1'b0, sel, 32'h0, 1'b0, ex);
    endtask

    task automatic wr(input sysid_sel_type sel, input logic [31:0] d);
        acc(1'b1, sel, d, 1'b0, 32'h0);
    endtask

    task automatic bad(input logic w, input sysid_sel_type sel);
        acc(w, sel, 32'h0000000F, 1'b1, 32'h0);
    endtask

    task automatic idle(input int n);
        i_acc_valid = 1'b0;
        repeat (n) begin
            @(posedge i_core_clk);
            #1;
            `CHK("idle_done", 1'b0, o_acc_rsp.done)
        end
    endtask

    task automatic do_reset(input logic [3:0] cl, input logic [1:0] co,
        input logic l2);
        int n;
        i_acc_valid = 1'b0;
        i_rst_n = 1'b0;
        i_cluster_number_input = cl;
        i_core_number = co;
        i_l2_present = l2;
        repeat (4) @(posedge i_core_clk);
        #1;
        `CHK("ready_in_reset", 1'b0, o_acc_ready)
        `CHK("rsp_in_reset", 34'h0, o_acc_rsp)
        i_rst_n = 1'b1;
        n = 0;
        while (o_acc_ready !== 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        `CHK("ready_latency", 3, n)
        if (n >= 20) begin
            complete_run();
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        num_checks = 0;
        i_acc_req = '0;
        i_security_write_disable = 1'b0;
        do_reset(4'h3, 2'h2, 1'b1);
        rd(SEL_MAIN, MAIN_VAL);
        rd(SEL_ALIAS4, MAIN_VAL);
        rd(SEL_ALIAS7, MAIN_VAL);
        rd(SEL_CTYPE, 32'h84448003);
        rd(SEL_TCM, 32'h00000000);
        rd(SEL_TLB, 32'h00000000);
        rd(SEL_AFF, 32'h80000302);
        rd(SEL_VAFF, 32'h80000302);
        rd(SEL_VPROC, MAIN_VAL);
        rd(SEL_CLEVEL, CLEVEL_L2);
        rd(SEL_AUXID, 32'h00000000);
        for (int i = 0; i < 8; i++) begin
            rd(mk_sel(4'h0, 3'h0, 4'h1, i[2:0]), FEAT_EXP[i]);
        end
        for (int i = 0; i < 6; i++) begin
            rd(mk_sel(4'h0, 3'h0, 4'h2, i[2:0]), ISA_EXP[i]);
        end
        // nonzero primary numbers and unlisted selectors are refused
        for (int p = 1; p < 16; p++) begin
            bad(1'b0, mk_sel(p[3:0], 3'h0, 4'h0, 3'h0));
        end
        bad(1'b0, mk_sel(4'h0, 3'h0, 4'h2, 3'h6));
        bad(1'b0, mk_sel(4'h0, 3'h3, 4'h0, 3'h0));
        bad(1'b0, mk_sel(4'h0, 3'h1, 4'h0, 3'h2));
        wr(SEL_CTYPE, 32'hFFFFFFFF);
        rd(SEL_CTYPE, 32'h84448003);
        wr(SEL_MAIN, 32'h00000000);
        rd(SEL_MAIN, MAIN_VAL);
        wr(SEL_CSSEL, 32'hFFFFFFF0);
        rd(SEL_CSSEL, 32'h00000000);
        wr(SEL_CSSEL, 32'h00000001);
        rd(SEL_CSIZE, CSIZE_L1I);
        wr(SEL_CSSEL, 32'h00000002);
        rd(SEL_CSIZE, CSIZE_L2);
        wr(SEL_CSSEL, 32'h00000000);
        rd(SEL_CSIZE, CSIZE_L1D);
        wr(SEL_VPROC, 32'h12345678);
        rd(SEL_VPROC, 32'h12345678);
        wr(SEL_VAFF, 32'h0000ABCD);
        rd(SEL_VAFF, 32'h0000ABCD);
        // the disable pin is synchronised, so give it three edges
        i_security_write_disable = 1'b1;
        idle(3);
        bad(1'b1, SEL_CSSEL);
        bad(1'b1, SEL_VPROC);
        bad(1'b1, SEL_VAFF);
        rd(SEL_CSSEL, 32'h00000000);
        rd(SEL_VPROC, 32'h12345678);
        wr(SEL_CTYPE, 32'h00000000);
        i_security_write_disable = 1'b0;
        idle(3);
        wr(SEL_CSSEL, 32'h00000001);
        rd(SEL_CSSEL, 32'h00000001);
        idle(1);
        // second reset in mid-run with other straps and no level two
        do_reset(4'hA, 2'h1, 1'b0);
        rd(SEL_AFF, 32'h80000A01);
        rd(SEL_VAFF, 32'h80000A01);
        rd(SEL_VPROC, MAIN_VAL);
        rd(SEL_CLEVEL, CLEVEL_L1);
        wr(SEL_CSSEL, 32'h00000002);
        rd(SEL_CSIZE, 32'h00000000);
        i_cluster_number_input = 4'h5;
        i_l2_present = 1'b1;
        idle(4);
        rd(SEL_AFF, 32'h80000A01);
        rd(SEL_CLEVEL, CLEVEL_L1);
        idle(1);
        complete_run();
    end
endmodule // sysid_bank_test
